// [rtl/icm_top.sv]
// icm_top: input conditioning, virtual flags, keys and output matrix
// assumes: one 100 MHz clock, pins are asynchronous, sources synchronous
`timescale 1ns/1ps
`default_nettype none
`include "icm_params.svh"
module icm_top #(
  parameter int TICK_CYC = `ICM_TICK_TIME_NS / `ICM_CLK_PERIOD_NS
) (
  // clock, reset, enable
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic        ce,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // field pins
  input  wire logic        hw_input_one_pin,
  input  wire logic        hw_input_two_pin,
  input  wire logic        front_key_one,
  input  wire logic        front_key_two,
  // internal sources and release requests
  input  wire logic [9:0]  ext_src,
  input  wire logic        release_panel,
  input  wire logic        release_comm,
  // input status and events
  output logic      [1:0]  di_status,
  output logic      [1:0]  di_popup,
  output logic      [1:0]  di_on_event,
  output logic      [1:0]  di_off_event,
  output logic      [3:0]  virtual_input_flags,
  output logic      [1:0]  key_obj_cmd,
  // matrix destinations
  output logic      [4:0]  relay_out,
  output logic      [5:0]  virtual_output,
  output logic      [7:0]  led_out,
  output logic      [1:0]  key_led,
  output logic             disturbance_recorder_trigger
);

  icm_pkg::icm_top_t        r;
  icm_pkg::icm_top_t        n;
  icm_di_if                 dif [2] ();

  logic [1:0]               di_st;
  logic [1:0]               di_act;
  logic [1:0][15:0]         di_cnt;
  logic [`ICM_NSRC-1:0]     src;
  logic [`ICM_NDEST-1:0]    drive;
  logic [`ICM_NDEST-1:0]    clr;
  logic [7:0]               led_drv;
  logic [7:0]               old;
  logic [1:0]               key_edge;
  logic                     new_ev;
  logic                     rel_all;
  logic                     wr_ctrl;
  logic [1:0]               tgt;
  logic [5:0]               midx;

  function automatic logic route(input logic [`ICM_NSRC-1:0] m,
                                 input logic [`ICM_NSRC-1:0] s);
    route = |(m & s);
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction

  // channel hookup
  for (genvar g = 0; g < 2; g++) begin : g_chan
    assign dif[g].ce        = ce;
    assign dif[g].tick      = r.tick;
    assign dif[g].raw       = r.sync1[g];
    assign dif[g].inv       = r.di_cfg[4*g+`ICM_CFG_INV];
    assign dif[g].pop_en    = r.di_cfg[4*g+`ICM_CFG_POP];
    assign dif[g].on_en     = r.di_cfg[4*g+`ICM_CFG_ON];
    assign dif[g].off_en    = r.di_cfg[4*g+`ICM_CFG_OFF];
    assign dif[g].delay     = r.dly[g];
    assign dif[g].cnt_wr    = reg_wr && r.unlock &&
      hit(reg_addr, g ? `ICM_OFF_CNT1 : `ICM_OFF_CNT0);
    assign dif[g].cnt_wdata = reg_wdata[15:0];
    assign di_st[g]         = dif[g].state;
    assign di_act[g]        = dif[g].act;
    assign di_cnt[g]        = dif[g].count;
    assign di_popup[g]      = dif[g].pop;
    assign di_on_event[g]   = dif[g].on_ev;
    assign di_off_event[g]  = dif[g].off_ev;
    icm_di_chan u_chan (
      .sys_clk (sys_clk),
      .arst_n  (arst_n),
      .port    (dif[g].chan)
    );
  end

  // matrix source vector
  // flags usable as inputs
  assign src = {ext_src, r.vflags, di_st};

  always_comb begin
    for (int d = 0; d < `ICM_NDEST; d++) begin
      drive[d] = route(r.mask[d], src);
    end
  end

  assign led_drv = drive[`ICM_D_LED +: 8];
  assign new_ev  = |(led_drv & ~r.led_prev);

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      old[i] = r.dest[`ICM_D_LED+i] && r.latch[`ICM_D_LED+i] &&
               !led_drv[i] && (r.age_cnt[i] >= r.age);
    end
  end

  assign wr_ctrl = reg_wr && hit(reg_addr, `ICM_OFF_CTRL);
  assign rel_all = (wr_ctrl && reg_wdata[`ICM_CTRL_REL]) ||
                   release_panel || release_comm ||
                   (r.di_cfg[`ICM_CFG_RELEN] &&
                    di_act[r.di_cfg[`ICM_CFG_RELSEL]]);

  always_comb begin
    clr = {`ICM_NDEST{rel_all}};
    if (r.auto_en && new_ev) begin
      clr[`ICM_D_LED +: 8] = clr[`ICM_D_LED +: 8] | old;
    end
  end

  assign key_edge = r.sync1[3:2] & ~r.kprev;

  always_comb begin
    n         = r;
    tgt       = 2'h0;
    midx      = 6'h0;
    // time base
    n.tick    = 1'b0;
    if (r.pre == 20'(TICK_CYC - 1)) begin
      n.pre  = '0;
      n.tick = 1'b1;
    end else begin
      n.pre = r.pre + 20'h1;
    end
    // two-stage pin synchronisers
    n.sync0   = {front_key_two, front_key_one,
                 hw_input_two_pin, hw_input_one_pin};
    n.sync1   = r.sync0;
    n.kprev   = r.sync1[3:2];
    // register writes
    if (reg_wr) begin
      n.unlock = 1'b0;
      if (hit(reg_addr, `ICM_OFF_DI_CFG)) begin
        n.di_cfg = reg_wdata[9:0];
      end
      if (hit(reg_addr, `ICM_OFF_DLY0)) begin
        n.dly[0] = reg_wdata[`ICM_DELAY_W-1:0];
      end
      if (hit(reg_addr, `ICM_OFF_DLY1)) begin
        n.dly[1] = reg_wdata[`ICM_DELAY_W-1:0];
      end
      if (hit(reg_addr, `ICM_OFF_UNLOCK)) begin
        n.unlock = (reg_wdata == `ICM_UNLOCK_KEY);
      end
      if (hit(reg_addr, `ICM_OFF_VFLAGS)) begin
        n.vflags = reg_wdata[3:0];
      end
      if (hit(reg_addr, `ICM_OFF_KEYCFG)) begin
        n.keycfg = reg_wdata[5:0];
      end
      if (hit(reg_addr, `ICM_OFF_LATCH)) begin
        n.latch = reg_wdata[`ICM_NDEST-1:0];
      end
      if (wr_ctrl) begin
        n.auto_en = reg_wdata[`ICM_CTRL_AUTO];
      end
      if (hit(reg_addr, `ICM_OFF_AGE)) begin
        n.age = reg_wdata[`ICM_AGE_W-1:0];
      end
      if (reg_addr >= `ICM_OFF_MASK0 && reg_addr[1:0] == 2'h0) begin
        midx = reg_addr[7:2] - 6'h10;
        if (midx < 6'(`ICM_NDEST)) begin
          n.mask[midx] = reg_wdata[`ICM_NSRC-1:0];
        end
      end
    end
    n.obj_key = 2'h0;
    for (int k = 0; k < 2; k++) begin
      if (key_edge[k]) begin
        if (icm_pkg::icm_keyfn_t'(r.keycfg[`ICM_KEY_OBJ0+k]) ==
            icm_pkg::ICM_KEY_OBJ) begin
          n.obj_key[k] = 1'b1;
        end else begin
          tgt           = r.keycfg[2*k +: 2];
          n.vflags[tgt] = ~n.vflags[tgt];
        end
      end
    end
    n.dest     = drive | (r.dest & r.latch & ~clr);
    n.led_prev = led_drv;
    for (int i = 0; i < 8; i++) begin
      if (led_drv[i] || !r.dest[`ICM_D_LED+i]) begin
        n.age_cnt[i] = '0;
      end else if (r.tick && r.age_cnt[i] < r.age) begin
        n.age_cnt[i] = r.age_cnt[i] + `ICM_AGE_W'(1);
      end
    end
    // read data, one cycle after the strobe only
    n.rdata = 32'h0;
    if (reg_rd) begin
      unique case (reg_addr)
        `ICM_OFF_DI_CFG: n.rdata = {22'h0, r.di_cfg};
        `ICM_OFF_DLY0:   n.rdata = 32'(r.dly[0]);
        `ICM_OFF_DLY1:   n.rdata = 32'(r.dly[1]);
        `ICM_OFF_CNT0:   n.rdata = {16'h0, di_cnt[0]};
        `ICM_OFF_CNT1:   n.rdata = {16'h0, di_cnt[1]};
        `ICM_OFF_UNLOCK: n.rdata = {31'h0, r.unlock};
        `ICM_OFF_VFLAGS: n.rdata = {28'h0, r.vflags};
        `ICM_OFF_KEYCFG: n.rdata = {26'h0, r.keycfg};
        `ICM_OFF_LATCH:  n.rdata = 32'(r.latch);
        `ICM_OFF_CTRL:   n.rdata = {31'h0, r.auto_en};
        `ICM_OFF_AGE:    n.rdata = 32'(r.age);
        `ICM_OFF_STATUS: n.rdata = {26'h0, r.vflags, di_st};
        `ICM_OFF_DEST:   n.rdata = 32'(r.dest);
        default: begin
          midx = reg_addr[7:2] - 6'h10;
          if (reg_addr >= `ICM_OFF_MASK0 && reg_addr[1:0] == 2'h0 &&
              midx < 6'(`ICM_NDEST)) begin
            n.rdata = 32'(r.mask[midx]);
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      r        <= '0;
      r.di_cfg <= `ICM_RST_DI_CFG;
      r.keycfg <= `ICM_RST_KEYCFG;
      r.age    <= `ICM_RST_AGE;
    end else if (ce) begin
      r <= n;
    end
  end

  // outputs
  // conditioned input status
  assign di_status                    = di_st;
  assign virtual_input_flags          = r.vflags;
  assign key_obj_cmd                  = r.obj_key;
  assign reg_rdata                    = r.rdata;
  assign relay_out                    = r.dest[4:0];
  assign virtual_output               = r.dest[`ICM_D_VO +: 6];
  assign led_out                      = r.dest[`ICM_D_LED +: 8];
  assign key_led                      = r.dest[`ICM_D_KLED +: 2];
  assign disturbance_recorder_trigger = r.dest[`ICM_D_REC];

  a_status_out: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    di_act != 2'h0 |-> (di_status & di_act) == di_act)
    else $error("active edge without active status");

  a_nonlatch_track: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    ce |=> ((r.dest ^ $past(drive)) & ~$past(r.latch)) == '0)
    else $error("non-latched output not following its signal");

  a_latch_hold: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    ce && !rel_all && !(r.auto_en && new_ev)
    |=> ($past(r.dest) & $past(r.latch) & ~r.dest) == '0)
    else $error("latched output dropped without release");

  a_release_all: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    ce && rel_all |=> (r.dest & ~$past(drive)) == '0)
    else $error("release left an undriven output set");

  a_key_toggle: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    ce && !reg_wr && key_edge == 2'h1 && !r.keycfg[`ICM_KEY_OBJ0]
    |=> r.vflags[$past(r.keycfg[1:0])] != $past(r.vflags[r.keycfg[1:0]]))
    else $error("key press did not toggle its flag");

  a_key_object: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    ce && key_edge[0] && r.keycfg[`ICM_KEY_OBJ0] |=> key_obj_cmd[0])
    else $error("object key press gave no command pulse");

  a_flag_hold: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    ce && !reg_wr && key_edge == 2'h0
    |=> virtual_input_flags == $past(virtual_input_flags))
    else $error("virtual flags changed without write or key");

  a_vout_set: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    ce |=> (virtual_output & $past(drive[`ICM_D_VO +: 6])) ==
           $past(drive[`ICM_D_VO +: 6]))
    else $error("driven virtual output not set");

  a_recorder_dest: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    ce && drive[`ICM_D_REC] |=> disturbance_recorder_trigger)
    else $error("recorder trigger not raised by its source");

  a_auto_clear: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    ce && r.auto_en && new_ev |=> (led_out & $past(old)) == 8'h0)
    else $error("old latched led kept after a new event");

  a_input_release: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    ce && r.di_cfg[`ICM_CFG_RELEN] && di_act[r.di_cfg[`ICM_CFG_RELSEL]]
    |=> (r.dest & ~$past(drive)) == '0)
    else $error("release by input left an undriven output set");

endmodule
`default_nettype wire

// [inc/icm_params.svh]
// icm_params.svh: register offsets, field positions, reset values, timing
// assumes: included by bare name from the package and the design files
`ifndef ICM_PARAMS_SVH
`define ICM_PARAMS_SVH

// timing
`define ICM_CLK_PERIOD_NS  10
`define ICM_TICK_TIME_NS   10000000
`define ICM_DELAY_W        13
`define ICM_AGE_W          16

// register byte offsets
`define ICM_OFF_DI_CFG     8'h00
`define ICM_OFF_DLY0       8'h04
`define ICM_OFF_DLY1       8'h08
`define ICM_OFF_CNT0       8'h0c
`define ICM_OFF_CNT1       8'h10
`define ICM_OFF_UNLOCK     8'h14
`define ICM_OFF_VFLAGS     8'h18
`define ICM_OFF_KEYCFG     8'h1c
`define ICM_OFF_LATCH      8'h20
`define ICM_OFF_CTRL       8'h24
`define ICM_OFF_AGE        8'h28
`define ICM_OFF_STATUS     8'h2c
`define ICM_OFF_DEST       8'h30
`define ICM_OFF_MASK0      8'h40

// input configuration fields, channel n at bit 4*n plus field, release select and enable shared
`define ICM_CFG_INV        0
`define ICM_CFG_POP        1
`define ICM_CFG_ON         2
`define ICM_CFG_OFF        3
`define ICM_CFG_RELSEL     8
`define ICM_CFG_RELEN      9
// control fields
`define ICM_CTRL_AUTO      0
`define ICM_CTRL_REL       8
// key configuration fields
`define ICM_KEY_TGT0       0
`define ICM_KEY_TGT1       2
`define ICM_KEY_OBJ0       4
`define ICM_KEY_OBJ1       5

// matrix layout
`define ICM_NSRC           16
`define ICM_NDEST          22
`define ICM_S_VF           2
`define ICM_S_EXT          6
`define ICM_D_VO           5
`define ICM_D_LED          11
`define ICM_D_KLED         19
`define ICM_D_REC          21

// reset values and unlock key
`define ICM_RST_DI_CFG     10'h0cc
`define ICM_RST_KEYCFG     6'h04
`define ICM_RST_AGE        16'h0064
`define ICM_UNLOCK_KEY     32'h0000a5c3

`endif

// [inc/icm_pkg.sv]
// icm_pkg: state types of the input conditioning and output matrix
// assumes: icm_params.svh on the include path
`include "icm_params.svh"
package icm_pkg;

  typedef enum logic {ICM_KEY_TOGGLE, ICM_KEY_OBJ} icm_keyfn_t;

  typedef struct packed {
    logic                     st;
    logic [`ICM_DELAY_W-1:0]  tmr;
    logic [15:0]              cnt;
    logic                     act;
    logic                     inact;
    logic                     pop;
    logic                     on_ev;
    logic                     off_ev;
  } icm_chan_t;

  typedef struct packed {
    logic [3:0]                          sync0;
    logic [3:0]                          sync1;
    logic [1:0]                          kprev;
    logic [19:0]                         pre;
    logic                                tick;
    logic [9:0]                          di_cfg;
    logic [1:0][`ICM_DELAY_W-1:0]        dly;
    logic                                unlock;
    logic [3:0]                          vflags;
    logic [5:0]                          keycfg;
    logic [1:0]                          obj_key;
    logic [`ICM_NDEST-1:0]               latch;
    logic                                auto_en;
    logic [`ICM_AGE_W-1:0]               age;
    logic [`ICM_NDEST-1:0][`ICM_NSRC-1:0] mask;
    logic [`ICM_NDEST-1:0]               dest;
    logic [7:0]                          led_prev;
    logic [7:0][`ICM_AGE_W-1:0]          age_cnt;
    logic [31:0]                         rdata;
  } icm_top_t;

endpackage

// [inc/icm_di_if.sv]
// icm_di_if: link between the matrix core and one input channel
// assumes: single clock domain, raw level already synchronised
`timescale 1ns/1ps
`default_nettype none
`include "icm_params.svh"
interface icm_di_if;
  logic                    ce;
  logic                    tick;
  logic                    raw;
  logic                    inv;
  logic                    pop_en;
  logic                    on_en;
  logic                    off_en;
  logic [`ICM_DELAY_W-1:0] delay;
  logic                    cnt_wr;
  logic [15:0]             cnt_wdata;
  logic                    state;
  logic                    act;
  logic                    pop;
  logic                    on_ev;
  logic                    off_ev;
  logic [15:0]             count;
  modport ctrl (output ce, tick, raw, inv, pop_en, on_en, off_en, delay,
                cnt_wr, cnt_wdata, input state, act, pop, on_ev, off_ev,
                count);
  modport chan (input ce, tick, raw, inv, pop_en, on_en, off_en, delay,
                cnt_wr, cnt_wdata, output state, act, pop, on_ev, off_ev,
                count);
endinterface
`default_nettype wire

// [rtl/icm_di_chan.sv]
// icm_di_chan: one hardware input, polarity, delay filter, edge counter
// assumes: raw input synchronised by the caller, tick is one cycle wide
`timescale 1ns/1ps
`default_nettype none
`include "icm_params.svh"
module icm_di_chan (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // core side
  icm_di_if.chan   port
);

  icm_pkg::icm_chan_t r;
  icm_pkg::icm_chan_t n;
  logic               lvl;

  always_comb begin
    n        = r;
    lvl      = port.raw ^ port.inv;
    n.act    = 1'b0;
    n.inact  = 1'b0;
    if (lvl == r.st) begin
      n.tmr = '0;
    end else if (r.tmr >= port.delay) begin
      n.st    = lvl;
      n.tmr   = '0;
      n.act   = lvl;
      n.inact = ~lvl;
    end else if (port.tick) begin
      n.tmr = r.tmr + `ICM_DELAY_W'(1);
    end
    n.pop    = n.act & port.pop_en;
    n.on_ev  = n.act & port.on_en;
    n.off_ev = n.inact & port.off_en;
    if (port.cnt_wr) begin
      n.cnt = port.cnt_wdata;
    end else if (n.act) begin
      n.cnt = r.cnt + 16'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '0;
    end else if (port.ce) begin
      r <= n;
    end
  end

  assign port.state  = r.st;
  assign port.act    = r.act;
  assign port.pop    = r.pop;
  assign port.on_ev  = r.on_ev;
  assign port.off_ev = r.off_ev;
  assign port.count  = r.cnt;

  a_delay_wait: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    port.ce && lvl != r.st && r.tmr < port.delay |=> r.st == $past(r.st))
    else $error("input accepted before its delay");

  a_rise_active: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    port.ce && n.act && !port.inv |-> port.raw)
    else $error("active edge without high pin when not inverted");

  a_fall_active: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    port.ce && n.act && port.inv |-> !port.raw)
    else $error("active edge without low pin when inverted");

  a_event_gate: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    r.on_ev |-> r.act && r.st)
    else $error("on event without active edge");

  a_edge_count: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    port.ce && n.act && !port.cnt_wr |=> r.cnt == $past(r.cnt) + 16'h1)
    else $error("edge counter did not advance");

endmodule
`default_nettype wire

// [tb/icm_field_model.sv]
// icm_field_model: field contacts on the two inputs, relay armatures
// assumes: contact_cmd changes just after a clock edge, one clock domain
`timescale 1ns/1ps
`default_nettype none
module icm_field_model #(
  parameter int LAG = 3
) (
  // clock
  input  wire logic       sys_clk,
  // contact positions asked for, coils seen
  input  wire logic [1:0] contact_cmd,
  input  wire logic [4:0] relay_coil,
  // field wiring
  output logic      [1:0] pin,
  output logic      [4:0] coil_contact
);
  logic [LAG-1:0][1:0] travel;
  // contacts settle LAG cycles after the command, armatures one cycle
  always_ff @(posedge sys_clk) begin
    travel       <= {travel[LAG-2:0], contact_cmd};
    coil_contact <= relay_coil;
  end
  assign pin = travel[LAG-1];
endmodule
`default_nettype wire

// [tb/testbench.sv]
// testbench: self-checking bench of icm_top with the field model
// assumes: design and field model compiled first, TICK_CYC set to 4
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        sys_clk, arst_n, ce, reg_wr, reg_rd, rec;
  logic [7:0]  reg_addr, led_out;
  logic [31:0] reg_wdata, reg_rdata;
  logic [1:0]  cmd, pins, keys, di_status, di_popup, di_on_event;
  logic [1:0]  di_off_event, key_obj_cmd, key_led, ev_on, ev_off, ev_pop;
  logic        rel_p, rel_c;
  logic [9:0]  ext_src;
  logic [3:0]  virtual_input_flags;
  logic [4:0]  relay_out, coil;
  logic [5:0]  virtual_output;
  logic [21:0] dests;
  int          num_errors, n_tests, n;
  // destination index beside the ext_src bit routed to it
  int rows [9][2] = '{'{0, 0}, '{4, 1}, '{5, 2}, '{10, 3}, '{11, 4},
                      '{18, 5}, '{19, 6}, '{20, 7}, '{21, 9}};

  assign dests = {rec, key_led, led_out, virtual_output, relay_out};

  icm_top #(.TICK_CYC(4)) u_dut (
    .sys_clk(sys_clk), .arst_n(arst_n), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .hw_input_one_pin(pins[0]),
    .hw_input_two_pin(pins[1]), .front_key_one(keys[0]),
    .front_key_two(keys[1]), .ext_src(ext_src), .release_panel(rel_p),
    .release_comm(rel_c), .di_status(di_status), .di_popup(di_popup),
    .di_on_event(di_on_event), .di_off_event(di_off_event),
    .virtual_input_flags(virtual_input_flags), .key_obj_cmd(key_obj_cmd),
    .relay_out(relay_out), .virtual_output(virtual_output),
    .led_out(led_out), .key_led(key_led),
    .disturbance_recorder_trigger(rec));

  icm_field_model #(.LAG(3)) u_field (.sys_clk(sys_clk),
    .contact_cmd(cmd), .relay_coil(relay_out), .pin(pins),
    .coil_contact(coil));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [31:0] seen, exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict;
    if (num_errors == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic ticks(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                     input string what);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e, what);
  endtask

  // waits for a filtered level, keeps the pulses of that cycle
  task automatic wait_di(input int ch, input logic lvl);
    n = 0;
    while (di_status[ch] !== lvl && n < 60) begin
      @(posedge sys_clk);
      #1 n++;
    end
    ev_on  = di_on_event;
    ev_off = di_off_event;
    ev_pop = di_popup;
    chk(n < 60, 1, "input settle");  // settles
  endtask

  task automatic pulse(input logic [9:0] v);
    @(posedge sys_clk);
    ext_src <= v;
    repeat (2) @(posedge sys_clk);
    ext_src <= '0;
    ticks(4);
  endtask

  task automatic press(input int k);
    @(posedge sys_clk);
    keys[k] <= 1'b1;
    repeat (4) @(posedge sys_clk);
    keys[k] <= 1'b0;
    ticks(6);
  endtask

  initial begin
    {arst_n, reg_wr, reg_rd, keys, rel_p, rel_c, cmd} = '0;
    ce = 1'b1;
    reg_addr = '0;
    reg_wdata = '0;
    ext_src = '0;
    num_errors = 0;
    n_tests = 0;
    ticks(5);
    chk({dests, di_status, virtual_input_flags}, 0, "reset outs");
    @(posedge sys_clk);
    arst_n <= 1'b1;
    rdc(8'h00, 32'h0cc, "di_cfg reset");   // events enabled
    rdc(8'h1c, 32'h04, "keycfg reset");    // default keys
    rdc(8'h28, 32'h64, "age reset");       // age default
    rdc(8'h3c, 32'h0, "unmapped read");    // no mask there
    ticks(1);
    chk(reg_rdata, 0, "rdata after");      // one cycle
    foreach (rows[i]) begin
      wr(8'h40 + 8'(4 * rows[i][0]), 32'h40 << rows[i][1]);
      @(posedge sys_clk);
      ext_src <= 10'h1 << rows[i][1];
      ticks(3);
      chk(dests, 32'h1 << rows[i][0], "dest set");   // routed
      rdc(8'h30, 32'h1 << rows[i][0], "dest reg");
      @(posedge sys_clk);
      ext_src <= '0;
      ticks(3);
      chk(dests, 0, "dest follow");                  // follows
      wr(8'h40 + 8'(4 * rows[i][0]), 32'h0);
    end
    // input two inverted, input one with popup and no off event
    wr(8'h00, 32'h0d6);
    wait_di(1, 1'b1);
    chk(ev_on[1], 1, "inverted on");          // falling active
    rdc(8'h10, 32'h1, "count two");           // counted
    @(posedge sys_clk);
    cmd[1] <= 1'b1;
    wait_di(1, 1'b0);
    chk(ev_off[1], 1, "off event");           // inactive edge
    @(posedge sys_clk);
    cmd[0] <= 1'b1;
    wait_di(0, 1'b1);
    chk({ev_pop[0], ev_on[0]}, 2'b11, "on");
    @(posedge sys_clk);
    cmd[0] <= 1'b0;
    wait_di(0, 1'b0);
    chk(ev_off[0], 0, "off masked");          // disabled
    // a glitch shorter than the delay is dropped
    wr(8'h04, 32'h3);
    @(posedge sys_clk);
    cmd[0] <= 1'b1;
    repeat (6) @(posedge sys_clk);
    cmd[0] <= 1'b0;
    ticks(40);
    chk(di_status[0], 0, "glitch");           // restart
    @(posedge sys_clk);
    cmd[0] <= 1'b1;
    wait_di(0, 1'b1);
    chk(n >= 10, 1, "definite delay");        // delay applied
    wr(8'h0c, 32'h1234);
    rdc(8'h0c, 32'h2, "count locked");        // protected
    wr(8'h14, 32'ha5c3);
    wr(8'h0c, 32'hffff);
    rdc(8'h0c, 32'hffff, "count write");      // writable
    @(posedge sys_clk);
    cmd[0] <= 1'b0;
    wait_di(0, 1'b0);
    @(posedge sys_clk);
    cmd[0] <= 1'b1;
    wait_di(0, 1'b1);
    rdc(8'h0c, 32'h0, "count wrap");          // range end
    // virtual flags and keys
    wr(8'h18, 32'h5);
    ticks(1);
    chk(virtual_input_flags, 4'h5, "flags");  // writable
    press(0);
    chk(virtual_input_flags, 4'h4, "key one");  // toggles
    press(1);
    chk(virtual_input_flags, 4'h6, "key two");  // toggles
    rdc(8'h2c, 32'h19, "status");               // status
    // key one reassigned to object control, then a frozen write
    wr(8'h1c, 32'h14);
    @(posedge sys_clk);
    keys[0] <= 1'b1;
    ticks(3);
    chk({key_obj_cmd, virtual_input_flags}, 6'h16, "key object");
    @(posedge sys_clk);
    {keys[0], ce} <= 2'b00;
    wr(8'h18, 32'hf);
    ticks(1);
    chk(virtual_input_flags, 4'h6, "frozen");   // held
    @(posedge sys_clk);
    ce <= 1'b1;
    ticks(6);
    // latched relay and LED, three release paths
    wr(8'h20, 32'h801);
    wr(8'h40, 32'h40);
    wr(8'h6c, 32'h40);
    for (int k = 0; k < 3; k++) begin
      pulse(10'h1);
      chk({coil[0], led_out[0]}, 2'b11, "latched");  // holds
      if (k == 2) begin
        wr(8'h24, 32'h100);
      end else begin
        @(posedge sys_clk);
        {rel_c, rel_p} <= (k == 0) ? 2'b01 : 2'b10;
        @(posedge sys_clk);
        {rel_c, rel_p} <= 2'b00;
      end
      ticks(3);
      chk({relay_out[0], led_out[0]}, 0, "release");
    end
    // auto clear of stale LEDs
    wr(8'h20, 32'h1800);
    wr(8'h70, 32'h80);
    wr(8'h28, 32'h5);
    wr(8'h24, 32'h1);
    pulse(10'h1);
    ticks(40);
    pulse(10'h2);
    chk(led_out[1:0], 2'b10, "auto clear");   // old dropped
    pulse(10'h1);
    chk(led_out[1:0], 2'b11, "fresh kept");   // not yet old
    // release by an active edge of input one
    wr(8'h00, 32'h2d6);
    @(posedge sys_clk);
    cmd[0] <= 1'b0;
    wait_di(0, 1'b0);
    @(posedge sys_clk);
    cmd[0] <= 1'b1;
    wait_di(0, 1'b1);
    ticks(2);
    chk(led_out[1:0], 2'b00, "input release");  // by input
    @(posedge sys_clk);
    arst_n <= 1'b0;
    ticks(2);
    chk({dests, virtual_input_flags}, 0, "mid reset");
    give_verdict();
  end

  initial begin
    #200us;
    num_errors++;
    give_verdict();
  end
endmodule
`default_nettype wire
